// ---- inc/oic_map.svh ----
// Register addresses, field positions, seeds and last bit indices of the checker.
`ifndef OIC_MAP_SVH
`define OIC_MAP_SVH
`define OIC_ADDR_STATUS   8'h0C
`define OIC_ADDR_MAKER    8'h0D
`define OIC_SC_USER_OK    4
`define OIC_SC_FACT_OK    2
`define OIC_SC_OFFS_OK    1
`define OIC_CRC_SEED      3'h7
`define OIC_F_LAST        6'h2F
`define OIC_U_LAST        6'h3F
`define OIC_MAKER_ZERO    8'h00
// Default maker nibbles; the values are arbitrary.
`define OIC_MAKER_DEF_HI  4'hA
`define OIC_MAKER_DEF_LO  4'h5
`endif

// ---- inc/oic_pkg.sv ----
// Types shared by the OTP integrity checker.
package oic_pkg;
    // Factory shadow copy: registers 0x00..0x04, config bits, stored CRC.
    typedef struct packed {
        logic [7:0] cfgBits;
        logic [7:0] reg04;
        logic [7:0] reg03;
        logic [7:0] reg02;
        logic [7:0] reg01;
        logic [7:0] reg00;
        logic [2:0] storedCrc;
    } oic_factory_t;
    // User shadow copy: registers 0x05..0x0B and 0x0D, stored code.
    typedef struct packed {
        logic [7:0] reg0D;
        logic [7:0] reg0B;
        logic [7:0] reg0A;
        logic [7:0] reg09;
        logic [7:0] reg08;
        logic [7:0] reg07;
        logic [7:0] reg06;
        logic [7:0] reg05;
        logic [2:0] storedCode;
    } oic_user_t;
    typedef struct packed {
        logic [5:0] fCnt;
        logic [2:0] fCrc;
        logic [5:0] uCnt;
        logic [2:0] uCrc;
        logic       fOk;
        logic       uOk;
        logic       offOk;
        logic       progPend;
        logic       nvmWr;
        logic [2:0] nvmCode;
        logic [3:0] makerHi;
        logic [3:0] makerLo;
        logic [7:0] rdData;
    } oic_state_t;
endpackage : oic_pkg

// ---- rtl/otp_integrity_check.sv ----
// OTP integrity checker: factory CRC, user code, status and maker code.
//
// Summary of operation
// - Offset ok flag goes to 0 when acceleration reaches offset limit.
// - Maker code is an 8-bit user OTP byte at 0x0D, init data only.
// - Zero maker code sends default nibbles, else upper then lower nibble.
// - Factory CRC check runs only while factory lock is set.
// - Factory CRC uses x^3+x+1, seeded with 111 each pass.
// - Factory CRC covers registers 0x00..0x04 and config bits, not lock.
// - Bits enter LSB first, registers in ascending address order.
// - Mismatch against stored 3-bit CRC clears factory ok flag.
// - Both checks read shadow register copies, never fuse cells.
// - User check is independent and runs only with user lock set.
// - Program command with user lock computes user code, writes NVM.
// - User code covers 0x05..0x0B and 0x0D, excluding user lock.
// - User code mismatch clears user ok flag.
// - Cleared integrity flags stay cleared until device reset.
// - Factory ok flag reads 0 after CRC error, 1 when clean.
`timescale 1ns/1ns
`default_nettype none
`include "oic_map.svh"
module otp_integrity_check (
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire oic_pkg::oic_factory_t factoryShadow,
    input  wire logic               factoryLock,
    input  wire oic_pkg::oic_user_t userShadow,
    input  wire logic               userLock,
    input  wire logic               userCodeProgrammed,
    input  wire logic               progExecute,
    input  wire logic               offsetLimitHit,
    input  wire logic [7:0]         regAddr,
    output wire logic [7:0]         regRdData,
    output wire logic [7:0]         statusCheck,
    output wire logic               nvmCodeWrite,
    output wire logic [2:0]         nvmCodeValue,
    output wire logic [3:0]         initMakerFieldUpper,
    output wire logic [3:0]         initMakerFieldLower
);
    import oic_pkg::*;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // One serial step of the x^3+x+1 CRC, data bit entering at the top.
    function automatic logic [2:0] crcStep(input logic [2:0] c,
                                           input logic       d);
        logic fb;
        fb = d ^ c[2];
        crcStep = {c[1], c[0] ^ fb, fb};
    endfunction : crcStep

    // Status byte built from the three ok flags; other bits read zero.
    function automatic logic [7:0] statusByte(input logic fOk,
                                              input logic uOk,
                                              input logic oOk);
        logic [7:0] s;
        s = 8'h00;
        s[`OIC_SC_USER_OK] = uOk;
        s[`OIC_SC_FACT_OK] = fOk;
        s[`OIC_SC_OFFS_OK] = oOk;
        statusByte = s;
    endfunction : statusByte

    // ************************************************************
    // Covered bit streams
    // ************************************************************
    // Only shadow copies are wired in; fuse cells never reach here.
    logic [47:0] factoryBits;
    logic [63:0] userBits;
    assign factoryBits = {factoryShadow.cfgBits, factoryShadow.reg04,
                          factoryShadow.reg03, factoryShadow.reg02,
                          factoryShadow.reg01,
                          factoryShadow.reg00};
    assign userBits = {userShadow.reg0D, userShadow.reg0B,
                       userShadow.reg0A, userShadow.reg09,
                       userShadow.reg08, userShadow.reg07,
                       userShadow.reg06, userShadow.reg05};

    // ************************************************************
    // State
    // ************************************************************
    oic_state_t st_q;
    oic_state_t st_d;
    logic [2:0] fNext;
    logic [2:0] uNext;
    logic       fEnd;
    logic       uEnd;
    logic       userCheckEn;

    assign fNext = crcStep(st_q.fCrc, factoryBits[st_q.fCnt]);
    assign uNext = crcStep(st_q.uCrc, userBits[st_q.uCnt]);
    assign fEnd = (st_q.fCnt == `OIC_F_LAST);
    assign uEnd = (st_q.uCnt == `OIC_U_LAST);
    assign userCheckEn = userLock & userCodeProgrammed;

    always_comb begin
        st_d = st_q;
        st_d.nvmWr = 1'b0;
        // Factory pass; an unlocked array parks the engine at the seed.
        if (!factoryLock) begin
            st_d.fCnt = 6'h00;
            st_d.fCrc = `OIC_CRC_SEED;
        end else if (fEnd) begin
            st_d.fCnt = 6'h00;
            st_d.fCrc = `OIC_CRC_SEED;
            if (fNext != factoryShadow.storedCrc) begin
                st_d.fOk = 1'b0;
            end
        end else begin
            st_d.fCnt = st_q.fCnt + 6'h01;
            st_d.fCrc = fNext;
        end
        // User pass runs whenever locked so a program request can finish.
        if (!userLock) begin
            st_d.uCnt = 6'h00;
            st_d.uCrc = `OIC_CRC_SEED;
            st_d.progPend = 1'b0;
        end else if (uEnd) begin
            st_d.uCnt = 6'h00;
            st_d.uCrc = `OIC_CRC_SEED;
            if (userCheckEn && (uNext != userShadow.storedCode)) begin
                st_d.uOk = 1'b0;
            end
            if (st_q.progPend) begin
                st_d.nvmWr = 1'b1;
                st_d.nvmCode = uNext;
                st_d.progPend = 1'b0;
            end
        end else begin
            st_d.uCnt = st_q.uCnt + 6'h01;
            st_d.uCrc = uNext;
        end
        // A request during the last bit waits for the next full pass.
        if (progExecute && userLock) begin
            st_d.progPend = 1'b1;
        end
        if (offsetLimitHit) begin
            st_d.offOk = 1'b0;
        end
        // Maker code only shapes init data, nothing in sensing.
        if (userShadow.reg0D == `OIC_MAKER_ZERO) begin
            st_d.makerHi = `OIC_MAKER_DEF_HI;
            st_d.makerLo = `OIC_MAKER_DEF_LO;
        end else begin
            st_d.makerHi = userShadow.reg0D[7:4];
            st_d.makerLo = userShadow.reg0D[3:0];
        end
        if (regAddr == `OIC_ADDR_STATUS) begin
            st_d.rdData = statusByte(st_q.fOk, st_q.uOk, st_q.offOk);
        end else if (regAddr == `OIC_ADDR_MAKER) begin
            st_d.rdData = userShadow.reg0D;
        end else begin
            st_d.rdData = 8'h00;
        end
    end

    // Flags only ever fall here; reset is the sole way back to 1.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{fCnt: 6'h00, fCrc: `OIC_CRC_SEED, uCnt: 6'h00,
                      uCrc: `OIC_CRC_SEED, fOk: 1'b1, uOk: 1'b1,
                      offOk: 1'b1, progPend: 1'b0, nvmWr: 1'b0,
                      nvmCode: 3'h0, makerHi: 4'h0, makerLo: 4'h0,
                      rdData: 8'h00};
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    logic [7:0] statusLive;
    assign statusLive = statusByte(st_q.fOk, st_q.uOk, st_q.offOk);
    assign statusCheck = statusLive;
    assign regRdData = st_q.rdData;
    assign nvmCodeWrite = st_q.nvmWr;
    assign nvmCodeValue = st_q.nvmCode;
    assign initMakerFieldUpper = st_q.makerHi;
    assign initMakerFieldLower = st_q.makerLo;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_offset_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        offsetLimitHit |=> !st_q.offOk)
        else $error("offset flag not cleared");

    a_offset_sticky: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !st_q.offOk |=> !st_q.offOk)
        else $error("offset flag recovered");

    a_maker_default: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        userShadow.reg0D == `OIC_MAKER_ZERO |=>
        st_q.makerHi == `OIC_MAKER_DEF_HI &&
        st_q.makerLo == `OIC_MAKER_DEF_LO)
        else $error("default maker code not sent");

    a_maker_nibbles: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        userShadow.reg0D != `OIC_MAKER_ZERO |=>
        {st_q.makerHi, st_q.makerLo} == $past(userShadow.reg0D))
        else $error("maker nibbles wrong");

    a_read_status: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        regAddr == `OIC_ADDR_STATUS |=> regRdData == $past(statusLive))
        else $error("status readback wrong");

    a_read_maker: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        regAddr == `OIC_ADDR_MAKER |=>
        regRdData == $past(userShadow.reg0D))
        else $error("maker readback wrong");

    a_read_unmapped: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        regAddr != `OIC_ADDR_STATUS && regAddr != `OIC_ADDR_MAKER |=>
        regRdData == 8'h00)
        else $error("unmapped address read nonzero");

    // ************************************************************
    // Factory engine and integrity flag assertions
    // ************************************************************
    // Stepping is checked bit by bit, so a skipped or repeated bit is
    // caught in the cycle it happens rather than only at the compare.
    a_factory_park: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !factoryLock |=> st_q.fCnt == 6'h00 && st_q.fCrc == `OIC_CRC_SEED)
        else $error("factory engine ran while unlocked");

    a_factory_lock: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(st_q.fOk) |-> $past(factoryLock))
        else $error("factory fault while unlocked");

    a_factory_seed: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        factoryLock && st_q.fCnt == 6'h00 |-> st_q.fCrc == `OIC_CRC_SEED)
        else $error("factory pass not seeded");

    a_factory_step: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        factoryLock && !fEnd |=>
        st_q.fCnt == $past(st_q.fCnt) + 6'h01 && st_q.fCrc == $past(fNext))
        else $error("factory pass skipped a bit");

    a_factory_compare: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        factoryLock && fEnd && fNext != factoryShadow.storedCrc |=>
        !st_q.fOk)
        else $error("factory mismatch not flagged");

    a_factory_pass: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(st_q.fOk) |-> $past(st_q.fCnt) == `OIC_F_LAST &&
        st_q.fCnt == 6'h00 && st_q.fCrc == `OIC_CRC_SEED)
        else $error("factory flag fell mid pass");

    a_flags_sticky: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !st_q.fOk || !st_q.uOk |=>
        $past(st_q.fOk) >= st_q.fOk && $past(st_q.uOk) >= st_q.uOk)
        else $error("integrity flag recovered");

    // ************************************************************
    // User engine and programming assertions
    // ************************************************************
    a_user_park: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !userLock |=> st_q.uCnt == 6'h00 && st_q.uCrc == `OIC_CRC_SEED &&
        !st_q.progPend)
        else $error("user engine ran while unlocked");

    a_user_seed: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        userLock && st_q.uCnt == 6'h00 |-> st_q.uCrc == `OIC_CRC_SEED)
        else $error("user pass not seeded");

    a_user_step: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        userLock && !uEnd |=>
        st_q.uCnt == $past(st_q.uCnt) + 6'h01 && st_q.uCrc == $past(uNext))
        else $error("user pass skipped a bit");

    a_user_compare: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        userCheckEn && uEnd && uNext != userShadow.storedCode |=>
        !st_q.uOk)
        else $error("user mismatch not flagged");

    a_user_enable: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(st_q.uOk) |-> $past(userCheckEn) &&
        $past(st_q.uCnt) == `OIC_U_LAST)
        else $error("user fault while disabled");

    // A request taken while the lock holds must reach NVM within about
    // two passes; dropping the lock cancels it, hence the lock window.
    a_nvm_write: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        progExecute && userLock && st_q.uCnt == 6'h00 ##1 userLock[*8]
        |-> ##[56:128] nvmCodeWrite)
        else $error("user code never written");

    a_nvm_value: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        st_q.progPend && userLock && uEnd |=>
        nvmCodeWrite && nvmCodeValue == $past(uNext))
        else $error("written user code wrong");

    a_nvm_pulse: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        nvmCodeWrite |=> !nvmCodeWrite)
        else $error("NVM write longer than one cycle");

    a_nvm_refused: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !userLock |=> !nvmCodeWrite)
        else $error("NVM written without user lock");

endmodule : otp_integrity_check
`default_nettype wire

// ---- sim/oic_otp_model.sv ----
// Model of the NVM cell that keeps the user error-detection code.
`timescale 1ns/1ns
`default_nettype none
module oic_otp_model (
    input  wire logic       clk_sys,
    input  wire logic       nvmCodeWrite,
    input  wire logic [2:0] nvmCodeValue,
    output var  logic       userCodeProgrammed,
    output var  logic [2:0] storedCode
);
    // ****************************************************************
    // Fuse cell
    // ****************************************************************
    // The cell ignores reset, as a blown fuse keeps its value.
    initial begin
        userCodeProgrammed = 1'b0;
        storedCode         = 3'h0;
    end
    always @(posedge clk_sys) begin
        if (nvmCodeWrite === 1'b1) begin
            storedCode         <= nvmCodeValue;
            userCodeProgrammed <= 1'b1;
        end
    end
endmodule : oic_otp_model
`default_nettype wire

// ---- sim/tb_otp_integrity_check.sv ----
// Self-checking testbench of the OTP integrity checker.
`timescale 1ns/1ns
`default_nettype none
`include "oic_map.svh"
module tb_otp_integrity_check;
    import oic_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_n   = 1'b0;
    logic [47:0] fData   = 48'h0;
    logic [2:0]  fCrc    = 3'h0;
    logic [63:0] uData   = 64'h0;
    logic        fLock   = 1'b0;
    logic        uLock   = 1'b0;
    logic        prog    = 1'b0;
    logic        offHit  = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [7:0]  mk;
    logic        wr;
    wire logic [7:0] rdData, status;
    wire logic       nvmWr, uProg;
    wire logic [2:0] nvmVal, stCode;
    wire logic [3:0] mkHi, mkLo;
    int mismatches = 0;
    int testsRun   = 0;

    always #50 clk_sys = ~clk_sys;

    otp_integrity_check dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .factoryShadow({fData, fCrc}), .factoryLock(fLock),
        .userShadow({uData, stCode}), .userLock(uLock),
        .userCodeProgrammed(uProg), .progExecute(prog),
        .offsetLimitHit(offHit), .regAddr(regAddr),
        .regRdData(rdData), .statusCheck(status), .nvmCodeWrite(nvmWr),
        .nvmCodeValue(nvmVal), .initMakerFieldUpper(mkHi),
        .initMakerFieldLower(mkLo));
    oic_otp_model otp (.clk_sys(clk_sys), .nvmCodeWrite(nvmWr),
        .nvmCodeValue(nvmVal), .userCodeProgrammed(uProg),
        .storedCode(stCode));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [2:0] crc3(input logic [63:0] d,
                                        input int n);
        logic [2:0] c;
        logic       fb;
        c = 3'h7;
        for (int i = 0; i < n; i++) begin
            fb = c[2] ^ d[i];
            c  = {c[1], c[0] ^ fb, fb};
        end
        return c;
    endfunction : crc3
    task automatic check(input string nm, input logic [7:0] seen, exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    // A flag may fall late in a pass, so allow two whole passes.
    task automatic wait_low(input int b);
        for (int i = 0; i < 140 && status[b] !== 1'b0; i++) cyc(1);
    endtask : wait_low
    task automatic pulse_prog;
        wr   = 1'b0;
        prog = 1'b1;
        cyc(1);
        prog = 1'b0;
        for (int i = 0; i < 140 && !wr; i++) begin
            wr = (nvmWr === 1'b1);
            if (!wr) cyc(1);
        end
    endtask : pulse_prog
    task automatic do_reset;
        rst_n = 1'b0;
        cyc(3);
        rst_n = 1'b1;
    endtask : do_reset
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #(5000 * 100);
        mismatches++;
        close_out();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        void'($urandom(32'h252F2D9D));
        cyc(1);
        do_reset();
        regAddr = `OIC_ADDR_STATUS;
        cyc(2);
        check("status read", rdData, 8'h16);
        for (int k = 0; k < 4; k++) begin
            mk = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
            uData[63:56] = mk;
            regAddr = (k == 3) ? 8'h3E : `OIC_ADDR_MAKER;
            cyc(2);
            check("maker read", rdData, (k == 3) ? 8'h00 : mk);
            check("maker fields", {mkHi, mkLo}, (mk == 8'h00) ?
                {`OIC_MAKER_DEF_HI, `OIC_MAKER_DEF_LO} : mk);
        end
        $display("maker test done");
        fData = 48'({$urandom, $urandom});
        fCrc  = ~crc3(64'(fData), 48);
        cyc(150);
        check("factory unlocked", status, 8'h16);
        fCrc  = crc3(64'(fData), 48);
        fLock = 1'b1;
        cyc(150);
        check("factory good", status, 8'h16);
        fData[47] = ~fData[47];
        wait_low(2);
        check("factory bad", status, 8'h12);
        fData[47] = ~fData[47];
        offHit = 1'b1;
        cyc(1);
        offHit = 1'b0;
        cyc(100);
        check("sticky flags", status, 8'h10);
        do_reset();
        cyc(100);
        check("after reset", status, 8'h16);
        $display("factory and offset test done");
        uData = {uData[63:56], 56'({$urandom, $urandom})};
        pulse_prog();
        check("refused write", {7'h0, wr}, 8'h00);
        uLock = 1'b1;
        pulse_prog();
        check("write seen", {7'h0, wr}, 8'h01);
        check("code", {5'h0, nvmVal}, {5'h0, crc3(uData, 64)});
        cyc(150);
        check("user good", status, 8'h16);
        uData[0] = ~uData[0];
        wait_low(4);
        check("user bad", status, 8'h06);
        $display("user test done");
        close_out();
    end
endmodule : tb_otp_integrity_check
`default_nettype wire
